// >>> inc/panel_pkg.sv
package panel_pkg;
  localparam int CLK_HZ      = 200_000_000;
  localparam int TICK_US     = 1000;
  localparam int TICK_CYC    = CLK_HZ / 1_000_000 * TICK_US;
  localparam int DEB_MS      = 10;
  localparam int FLASH_MS    = 250;
  localparam int HOLD_MS     = 5000;
  localparam int IDLE_MS     = 30000;
  localparam int BOOT_MS     = 25000;
  localparam int GAUGE_N     = 11;
  localparam int PAT_ENTERS  = 8;
  localparam int SEP_ENTERS  = 3;
  localparam int LEAD_MIL    = 12;
  localparam int SIDE_MIL    = 17;
  localparam logic [3:0] VAL_MIN = 4'h0;
  localparam logic [3:0] VAL_MAX = 4'ha;
  localparam logic [3:0] DENS_DEF = 4'h5;
  localparam logic [3:0] REG_DEF  = 4'h5;
  localparam logic [3:0] PAT_MIN  = 4'h4;
  localparam logic [3:0] PAT_MAX  = 4'h9;
  localparam logic [3:0] PAT_DEF  = 4'h4;
  localparam logic [3:0] SEP_MIN  = 4'h4;
  localparam logic [3:0] SEP_MAX  = 4'h6;
  localparam logic [3:0] SEP_DEF  = 4'h4;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_DENS = 8'h08;
  localparam logic [7:0] OFF_REGS = 8'h0c;
  localparam logic [7:0] OFF_OFFS = 8'h10;
  localparam int CTRL_READY = 0;
  localparam int CTRL_SAVE  = 1;
  localparam int CTRL_JOB   = 2;
  localparam int CTRL_RST   = 3;
  localparam int K_TEST  = 0;
  localparam int K_SEL   = 1;
  localparam int K_ENT   = 2;
  localparam int K_PLUS  = 3;
  localparam int K_MINUS = 4;

  typedef enum logic [4:0] {
    MD_BOOT = 5'b00001,
    MD_DENS = 5'b00010,
    MD_PAT  = 5'b00100,
    MD_SEP  = 5'b01000,
    MD_SVC  = 5'b10000
  } mode_type;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_type;

  typedef struct packed {
    logic [3:0]         tonerLed;
    logic [GAUGE_N-1:0] gaugeLed;
    logic               testPageReq;
    logic               startupChime;
    logic [3:0]         pattern;
    logic [3:0]         sepDesig;
  } panel_out_type;

  typedef struct packed {
    logic [4:0]       sy1;
    logic [4:0]       sy2;
    logic [4:0]       sy3;
    logic [4:0]       db;
    logic [4:0][3:0]  debCnt;
    logic [17:0]      tickCnt;
    logic [7:0]       flashCnt;
    logic             flash;
    mode_type         mode;
    logic             ready;
    logic             lock;
    logic [3:0][3:0]  dShow;
    logic [3:0][3:0]  dSet;
    logic [2:0][3:0]  rShow;
    logic [2:0][3:0]  rSet;
    logic [3:0]       patShow;
    logic [3:0]       sepShow;
    logic [1:0]       colour;
    logic             colValid;
    logic [1:0]       item;
    logic             itemValid;
    logic [3:0]       enterCnt;
    logic [15:0]      holdCnt;
    logic [15:0]      idleCnt;
    logic             idleArm;
    logic [15:0]      bootCnt;
    logic [7:0]       awAddr;
    logic             awHave;
    logic [31:0]      wData;
    logic [3:0]       wStrb;
    logic             wHave;
    axi_rsp_type      rsp;
    panel_out_type    o;
  } state_type;
endpackage

// >>> src/density_panel_mode_controller.sv
// Contract
// - Test key requests page unless energy locked
// - Enter commits shown gauge value
// - Select steps colour, its toner lit
// - Plus/minus step value, gauge shows change
// - Ready: centre LED dark if non-default
// - Density only in ready, kept over restart
// - Plus+minus five seconds restores mode defaults
// - Select+eight enters: pattern mode, all flash
// - Pattern positions 4..9, flash while changed
// - Pattern mode exits after idle 30 s once a value is entered
// - Pattern resets to vertical line on restart
// - Select+three enters: separation, Y/K flash
// - Separation positions 4..6, flash while changed
// - Separation returns to automatic on restart
// - Test held 25 s at power-on: service
// - Service: once an item is chosen, black flashes, item light steady
// - Lead step 12 mil, others 17 mil
// - Registration offsets kept over restart
module density_panel_mode_controller
  import panel_pkg::*;
#(
  parameter int TickCyc = TICK_CYC,
  parameter int HoldMs  = HOLD_MS,
  parameter int IdleMs  = IDLE_MS,
  parameter int BootMs  = BOOT_MS
) (
  input  wire logic          core_clk,
  input  wire logic          reset,
  input  wire logic [4:0]    keyRaw,
  input  wire axi_req_type   axiReq,
  output axi_rsp_type        axiRsp,
  output panel_out_type      panel
);

  // Counters are sized in the package; refuse what they cannot hold.
  if (TickCyc < 1 || TickCyc >= 2 ** 18 || HoldMs < 1 ||
      HoldMs >= 2 ** 16 || IdleMs < 1 || IdleMs >= 2 ** 16 ||
      BootMs < 1 || BootMs >= 2 ** 16) begin
    $error("Counter parameter out of range");
  end

  state_type s_r;
  state_type s_nxt;

  // One-hot gauge pattern for a position.
  function automatic logic [GAUGE_N-1:0] gaugeOf(input logic [3:0] v);
    gaugeOf = '0;
    if (v <= VAL_MAX) gaugeOf[v] = 1'b1;
  endfunction

  // Bounded step of a shown value.
  function automatic logic [3:0] stepVal(input logic [3:0] v,
      input logic up, input logic dn, input logic [3:0] lo,
      input logic [3:0] hi);
    stepVal = v;
    if (up && !dn && v < hi) stepVal = v + 4'h1;
    if (dn && !up && v > lo) stepVal = v - 4'h1;
  endfunction

  // Signed offset in thousandths of an inch for a stored step.
  function automatic logic [7:0] offMil(input logic [3:0] v,
      input logic [7:0] step);
    logic [7:0] d;
    d = 8'({4'h0, v}) - 8'({4'h0, REG_DEF});
    offMil = 8'(d * step);
  endfunction

  // Byte-lane merge for register writes.
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  assign axiRsp = s_r.rsp;
  assign panel  = s_r.o;

  // Whole next state; one pass covers keys, modes, display and bus.
  always_comb begin
    logic        tick;
    logic [4:0]  pr;
    logic [4:0]  rl;
    logic        up;
    logic        dn;
    logic        restart;
    logic        differ;
    logic [3:0]  shown;
    logic [31:0] wv;
    logic [31:0] rv;
    s_nxt   = s_r;
    tick    = 1'b0;
    up      = 1'b0;
    dn      = 1'b0;
    pr      = '0;
    rl      = '0;
    restart = 1'b0;
    differ  = 1'b0;
    shown   = '0;
    wv      = '0;
    rv      = '0;
    s_nxt.o.testPageReq  = 1'b0;
    s_nxt.o.startupChime = 1'b0;

    // Millisecond enable from the core clock.
    if (s_r.tickCnt == 18'(TickCyc - 1)) begin
      s_nxt.tickCnt = '0;
      tick = 1'b1;
    end else begin
      s_nxt.tickCnt = s_r.tickCnt + 18'h1;
    end

    // Flash phase shared by every blinking light.
    if (tick) begin
      if (s_r.flashCnt == 8'(FLASH_MS - 1)) begin
        s_nxt.flashCnt = '0;
        s_nxt.flash = !s_r.flash;
      end else begin
        s_nxt.flashCnt = s_r.flashCnt + 8'h1;
      end
    end

    // Key pins: three stages, then a level must hold DEB_MS ticks.
    s_nxt.sy1 = keyRaw;
    s_nxt.sy2 = s_r.sy1;
    s_nxt.sy3 = s_r.sy2;
    for (int k = 0; k < 5; k++) begin
      if (s_r.sy2[k] == s_r.sy3[k] && s_r.sy3[k] != s_r.db[k]) begin
        if (tick) begin
          if (s_r.debCnt[k] == 4'(DEB_MS - 1)) begin
            s_nxt.db[k] = s_r.sy3[k];
            s_nxt.debCnt[k] = '0;
            pr[k] = s_r.sy3[k];
            rl[k] = !s_r.sy3[k];
          end else begin
            s_nxt.debCnt[k] = s_r.debCnt[k] + 4'h1;
          end
        end
      end else begin
        s_nxt.debCnt[k] = '0;
      end
    end
    up     = pr[K_PLUS];
    dn     = pr[K_MINUS];

    // Register bus: address and data taken in either order.
    if (axiReq.awvalid && s_r.rsp.awready) begin
      s_nxt.awAddr = axiReq.awaddr;
      s_nxt.awHave = 1'b1;
    end
    if (axiReq.wvalid && s_r.rsp.wready) begin
      s_nxt.wData = axiReq.wdata;
      s_nxt.wStrb = axiReq.wstrb;
      s_nxt.wHave = 1'b1;
    end
    if (s_r.awHave && s_r.wHave && !s_r.rsp.bvalid) begin
      s_nxt.awHave = 1'b0;
      s_nxt.wHave = 1'b0;
      s_nxt.rsp.bvalid = 1'b1;
      s_nxt.rsp.bresp = 2'b00;
      unique case (s_r.awAddr)
        OFF_CTRL: begin
          wv = merge({31'h0, s_r.ready}, s_r.wData, s_r.wStrb);
          s_nxt.ready = wv[CTRL_READY];
          restart = wv[CTRL_RST];
          if (wv[CTRL_JOB] || restart) s_nxt.lock = 1'b0;
          if (wv[CTRL_SAVE]) s_nxt.lock = 1'b1;
        end
        OFF_DENS: begin
          wv = merge({16'h0, s_r.dSet}, s_r.wData, s_r.wStrb);
          s_nxt.dSet = wv[15:0];
          s_nxt.dShow = wv[15:0];
        end
        OFF_REGS: begin
          wv = merge({20'h0, s_r.rSet}, s_r.wData, s_r.wStrb);
          s_nxt.rSet = wv[11:0];
          s_nxt.rShow = wv[11:0];
        end
        OFF_STAT, OFF_OFFS: ;
        default: s_nxt.rsp.bresp = 2'b10;
      endcase
    end
    if (s_r.rsp.bvalid && axiReq.bready) s_nxt.rsp.bvalid = 1'b0;
    s_nxt.rsp.awready = !s_nxt.awHave && !s_nxt.rsp.bvalid;
    s_nxt.rsp.wready  = !s_nxt.wHave && !s_nxt.rsp.bvalid;

    // Reads answer one cycle after the address is taken.
    if (axiReq.arvalid && s_r.rsp.arready) begin
      s_nxt.rsp.rvalid = 1'b1;
      s_nxt.rsp.rresp = 2'b00;
      unique case (axiReq.araddr)
        OFF_CTRL: rv = {28'h0, 2'b00, s_r.lock, s_r.ready};
        OFF_STAT: rv = {10'h0, s_r.itemValid, s_r.item, s_r.colValid,
                        s_r.colour, s_r.o.sepDesig, s_r.o.pattern,
                        s_r.idleArm, 2'b00, s_r.mode};
        OFF_DENS: rv = {16'h0, s_r.dSet};
        OFF_REGS: rv = {20'h0, s_r.rSet};
        OFF_OFFS: rv = {8'h0,
                        offMil(s_r.rSet[2], 8'(SIDE_MIL)),
                        offMil(s_r.rSet[1], 8'(SIDE_MIL)),
                        offMil(s_r.rSet[0], 8'(LEAD_MIL))};
        default: s_nxt.rsp.rresp = 2'b10;
      endcase
      s_nxt.rsp.rdata = rv;
    end
    if (s_r.rsp.rvalid && axiReq.rready) s_nxt.rsp.rvalid = 1'b0;
    s_nxt.rsp.arready = !s_nxt.rsp.rvalid;

    // Plus and minus held together: count toward a default restore.
    if (s_r.db[K_PLUS] && s_r.db[K_MINUS] && s_r.mode != MD_BOOT) begin
      if (tick && s_r.holdCnt != 16'(HoldMs)) begin
        s_nxt.holdCnt = s_r.holdCnt + 16'h1;
      end
    end else begin
      s_nxt.holdCnt = '0;
    end

    // Mode machine.
    unique case (s_r.mode)
      MD_BOOT: begin
        // The test key is judged only once its debounce span has passed,
        // or a key held from power-on would read as released.
        if (tick) s_nxt.bootCnt = s_r.bootCnt + 16'h1;
        if (s_r.db[K_TEST]) begin
          if (s_r.bootCnt >= 16'(BootMs)) begin
            s_nxt.mode = MD_SVC;
          end
        end else if (s_r.bootCnt > 16'(DEB_MS + 1)) begin
          s_nxt.mode = MD_DENS;
          s_nxt.o.startupChime = 1'b1;
        end
      end
      MD_DENS: begin
        if (pr[K_TEST] && !s_r.lock) begin
          s_nxt.o.testPageReq = 1'b1;
        end
        if (s_r.ready) begin
          if (pr[K_SEL]) begin
            s_nxt.colour = s_r.colValid ? s_r.colour + 2'h1 : 2'h0;
            s_nxt.colValid = 1'b1;
            s_nxt.enterCnt = '0;
          end
          if (pr[K_ENT] && s_r.db[K_SEL]) begin
            s_nxt.enterCnt = s_r.enterCnt + 4'h1;
          end else if (pr[K_ENT]) begin
            s_nxt.dSet = s_r.dShow;
          end
          if (rl[K_SEL]) begin
            // The count is judged at release, so three is not
            // mistaken for the first three of eight.
            s_nxt.enterCnt = '0;
            if (s_r.enterCnt == 4'(PAT_ENTERS)) begin
              s_nxt.mode = MD_PAT;
              s_nxt.idleArm = 1'b0;
            end else if (s_r.enterCnt == 4'(SEP_ENTERS)) begin
              s_nxt.mode = MD_SEP;
              s_nxt.idleArm = 1'b0;
            end
          end
          if (s_r.colValid) begin
            s_nxt.dShow[s_r.colour] = stepVal(s_r.dShow[s_r.colour],
                up, dn, VAL_MIN, VAL_MAX);
          end
          if (s_r.holdCnt == 16'(HoldMs - 1) && tick) begin
            s_nxt.dShow = {4{DENS_DEF}};
            s_nxt.dSet  = {4{DENS_DEF}};
          end
        end
      end
      MD_PAT, MD_SEP: begin
        if (s_r.mode == MD_PAT) begin
          s_nxt.patShow = stepVal(s_r.patShow, up, dn,
              PAT_MIN, PAT_MAX);
          if (pr[K_ENT]) s_nxt.o.pattern = s_r.patShow;
        end else begin
          s_nxt.sepShow = stepVal(s_r.sepShow, up, dn,
              SEP_MIN, SEP_MAX);
          if (pr[K_ENT]) s_nxt.o.sepDesig = s_r.sepShow;
        end
        if (s_r.holdCnt == 16'(HoldMs - 1) && tick) begin
          if (s_r.mode == MD_PAT) begin
            s_nxt.patShow = PAT_DEF;
            s_nxt.o.pattern = PAT_DEF;
          end else begin
            s_nxt.sepShow = SEP_DEF;
            s_nxt.o.sepDesig = SEP_DEF;
          end
        end
        // Idle exit runs only once a value has been entered.
        if (pr[K_ENT]) s_nxt.idleArm = 1'b1;
        if (|pr) begin
          s_nxt.idleCnt = '0;
        end else if (s_r.idleArm && tick) begin
          s_nxt.idleCnt = s_r.idleCnt + 16'h1;
        end
        if (s_r.idleArm && s_r.idleCnt == 16'(IdleMs)) begin
          s_nxt.mode = MD_DENS;
          s_nxt.idleArm = 1'b0;
          s_nxt.idleCnt = '0;
        end
      end
      MD_SVC: begin
        if (pr[K_SEL]) begin
          s_nxt.item = (s_r.itemValid && s_r.item != 2'h2) ?
                       s_r.item + 2'h1 : 2'h0;
          s_nxt.itemValid = 1'b1;
        end
        if (s_r.itemValid) begin
          s_nxt.rShow[s_r.item] = stepVal(s_r.rShow[s_r.item],
              up, dn, VAL_MIN, VAL_MAX);
          if (pr[K_ENT]) s_nxt.rSet = s_r.rShow;
        end
        if (s_r.holdCnt == 16'(HoldMs - 1) && tick) begin
          s_nxt.rShow = {3{REG_DEF}};
          s_nxt.rSet  = {3{REG_DEF}};
        end
      end
      default: s_nxt.mode = MD_DENS;
    endcase

    // Soft restart drops only the volatile selections.
    if (restart) begin
      s_nxt.o.pattern = PAT_DEF;
      s_nxt.patShow = PAT_DEF;
      s_nxt.o.sepDesig = SEP_DEF;
      s_nxt.sepShow = SEP_DEF;
      s_nxt.dShow = s_nxt.dSet;
      s_nxt.rShow = s_nxt.rSet;
      s_nxt.colValid = 1'b0;
      s_nxt.enterCnt = '0;
      s_nxt.idleArm = 1'b0;
      if (s_r.mode == MD_PAT || s_r.mode == MD_SEP) begin
        s_nxt.mode = MD_DENS;
      end
    end

    // Lights follow the registered state of this cycle.
    s_nxt.o.tonerLed = '0;
    s_nxt.o.gaugeLed = '0;
    unique case (s_r.mode)
      MD_DENS: begin
        if (s_r.colValid) begin
          s_nxt.o.tonerLed = 4'(1) << s_r.colour;
          shown = s_r.dShow[s_r.colour];
          if (shown != s_r.dSet[s_r.colour]) begin
            s_nxt.o.gaugeLed = gaugeOf(shown);
          end
        end else if (s_r.ready && s_r.dSet == {4{DENS_DEF}}) begin
          s_nxt.o.gaugeLed = gaugeOf(DENS_DEF);
        end
      end
      MD_PAT, MD_SEP: begin
        if (s_r.mode == MD_PAT) begin
          s_nxt.o.tonerLed = {4{s_r.flash}};
          shown = s_r.patShow;
          differ = shown != s_r.o.pattern;
        end else begin
          s_nxt.o.tonerLed = {s_r.flash, 2'b00, s_r.flash};
          shown = s_r.sepShow;
          differ = shown != s_r.o.sepDesig;
        end
        if (!differ || s_r.flash) begin
          s_nxt.o.gaugeLed = gaugeOf(shown);
        end
      end
      MD_SVC: begin
        if (s_r.itemValid) begin
          s_nxt.o.tonerLed = {s_r.flash, 3'(1) << s_r.item};
          shown = s_r.rShow[s_r.item];
          if (shown != s_r.rSet[s_r.item]) begin
            s_nxt.o.gaugeLed = gaugeOf(shown);
          end
        end
      end
      MD_BOOT: ;
      default: ;
    endcase
  end

  // Power-on reset puts every field at its default.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_r <= '{mode: MD_BOOT, dShow: {4{DENS_DEF}},
               dSet: {4{DENS_DEF}}, rShow: {3{REG_DEF}},
               rSet: {3{REG_DEF}}, patShow: PAT_DEF,
               sepShow: SEP_DEF,
               rsp: '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                      default: '0},
               o: '{pattern: PAT_DEF, sepDesig: SEP_DEF,
                    default: '0},
               default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// >>> dv/density_panel_mode_controller_checker.sv
module density_panel_mode_controller_checker
  import panel_pkg::*;
(
  input wire logic          core_clk,
  input wire logic          reset,
  input wire logic [4:0]    keyRaw,
  input wire axi_req_type   axiReq,
  input wire axi_rsp_type   axiRsp,
  input wire panel_out_type panel
);
  // Every check lives in the core clock domain and sleeps in reset.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // A page request needs the test key to have been down eight cycles earlier.
  property p_pageAfterKey;
    panel.testPageReq |-> $past(keyRaw[K_TEST], 8);
  endproperty
  a_pageAfterKey: assert property (p_pageAfterKey)
    else $error("page request without a held test key");

  property p_pagePulse;
    panel.testPageReq |=> !panel.testPageReq;
  endproperty
  a_pagePulse: assert property (p_pagePulse)
    else $error("page request longer than one cycle");

  property p_chimePulse;
    panel.startupChime |=> !panel.startupChime;
  endproperty
  a_chimePulse: assert property (p_chimePulse)
    else $error("startup sound pulse too long");

  property p_patRange;
    panel.pattern >= PAT_MIN && panel.pattern <= PAT_MAX;
  endproperty
  a_patRange: assert property (p_patRange)
    else $error("pattern outside positions four to nine");

  property p_sepRange;
    panel.sepDesig >= SEP_MIN && panel.sepDesig <= SEP_MAX;
  endproperty
  a_sepRange: assert property (p_sepRange)
    else $error("designation outside positions four to six");

  property p_gaugeOne;
    $onehot0(panel.gaugeLed);
  endproperty
  a_gaugeOne: assert property (p_gaugeOne)
    else $error("more than one gauge light lit");

  // The pattern only moves on an enter press, a restore or a write.
  property p_patCause;
    !$stable(panel.pattern) |->
      $past(keyRaw[K_ENT], 8) || axiRsp.bvalid || $past(axiRsp.bvalid) ||
      ($past(keyRaw[K_PLUS], 8) && $past(keyRaw[K_MINUS], 8));
  endproperty
  a_patCause: assert property (p_patCause)
    else $error("pattern changed without enter or write");

  property p_bHold;
    axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid;
  endproperty
  a_bHold: assert property (p_bHold)
    else $error("write response dropped before acceptance");

  property p_rUnmapped;
    axiReq.arvalid && axiRsp.arready && axiReq.araddr > OFF_OFFS
      |=> axiRsp.rvalid && axiRsp.rresp == 2'b10;
  endproperty
  a_rUnmapped: assert property (p_rUnmapped)
    else $error("unmapped read not answered with an error");
endmodule

bind density_panel_mode_controller density_panel_mode_controller_checker
  density_panel_mode_controller_checker_i (
             .core_clk(core_clk), .reset(reset), .keyRaw(keyRaw),
             .axiReq(axiReq), .axiRsp(axiRsp), .panel(panel));

// >>> dv/key_operator.sv
module key_operator
  import panel_pkg::*;
#(
  parameter int TapCyc = 80
) (
  input  wire logic core_clk,
  output logic [4:0] keyRaw
);
  timeunit 1ns;
  timeprecision 1ps;

  // No key is pressed at power-on.
  initial keyRaw = 5'h00;

  // A press chatters for a few cycles, as real contacts do.
  task automatic down(input int k);
    repeat (6) @(posedge core_clk) keyRaw[k] <= ~keyRaw[k];
    @(posedge core_clk) keyRaw[k] <= 1'b1;
  endtask

  task automatic up(input int k);
    @(posedge core_clk) keyRaw[k] <= 1'b0;
  endtask

  // Held and rested twice the debounce span so one tap is one event.
  task automatic tap(input int k);
    down(k);
    repeat (TapCyc) @(posedge core_clk);
    up(k);
    repeat (TapCyc) @(posedge core_clk);
  endtask
endmodule

// >>> dv/test_density_panel_mode_controller.sv
module test_density_panel_mode_controller
  import panel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic          core_clk = 1'b0;
  logic          reset    = 1'b1;
  logic [4:0]    keyRaw;
  axi_req_type   axiReq   = '0;
  axi_rsp_type   axiRsp;
  panel_out_type panel;
  int            fails    = 0;
  int            n_checks = 0;
  int            pages    = 0;
  int            chimes   = 0;

  // The clock runs at 200 MHz.
  always #2.5 core_clk = ~core_clk;

  // One-cycle pulses are counted as they pass.
  always @(posedge core_clk) begin
    if (panel.testPageReq === 1'b1) pages++;
    if (panel.startupChime === 1'b1) chimes++;
  end

  density_panel_mode_controller #(
    .TickCyc(4), .HoldMs(5), .IdleMs(60), .BootMs(6)
  ) density_panel_mode_controller_i (
    .core_clk(core_clk), .reset(reset), .keyRaw(keyRaw),
    .axiReq(axiReq), .axiRsp(axiRsp), .panel(panel)
  );

  key_operator key_operator_i (.core_clk(core_clk), .keyRaw(keyRaw));

  task automatic final_report();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Each channel is released on the edge where its ready is seen.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] resp);
    resp = 2'bxx;
    @(posedge core_clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr  <= a;
    axiReq.wvalid  <= 1'b1;
    axiReq.wdata   <= d;
    axiReq.wstrb   <= 4'hf;
    axiReq.bready  <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge core_clk);
      if (axiRsp.awready && axiReq.awvalid) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready && axiReq.wvalid) axiReq.wvalid <= 1'b0;
      if (axiRsp.bvalid) begin
        resp = axiRsp.bresp;
        axiReq.bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
    d = 'x;
    resp = 2'bxx;
    @(posedge core_clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr  <= a;
    axiReq.rready  <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(posedge core_clk);
      if (axiRsp.arready && axiReq.arvalid) axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid) begin
        d = axiRsp.rdata;
        resp = axiRsp.rresp;
        axiReq.rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check({30'h0, r}, 32'h0, "write response");
    // Lights follow one edge after the write lands.
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e, input string s);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check(d & m, e, s);
  endtask

  task automatic do_reset(input bit svc);
    @(posedge core_clk);
    reset <= 1'b1;
    chimes = 0;
    if (svc) key_operator_i.down(K_TEST);
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    repeat (200) @(posedge core_clk);
  endtask

  task automatic t_boot();
    do_reset(1'b0);
    check(chimes, 1, "chime");
    rd(OFF_STAT, 32'h1f, 32'h2, "mode");
    wr(OFF_CTRL, 32'h1);
    check(32'(panel.gaugeLed), 32'h20, "default light");
  endtask

  task automatic t_density();
    key_operator_i.tap(K_SEL);
    check(32'(panel.tonerLed), 32'h1, "yellow");
    key_operator_i.tap(K_SEL);
    check(32'(panel.tonerLed), 32'h2, "magenta");
    key_operator_i.tap(K_PLUS);
    check(32'(panel.gaugeLed), 32'h40, "changed");
    key_operator_i.tap(K_ENT);
    check(32'(panel.gaugeLed), 32'h0, "entered");
    rd(OFF_DENS, 32'hffff, 32'h5565, "dens");
    // Out of ready the keys must leave the setting alone.
    wr(OFF_CTRL, 32'h0);
    key_operator_i.tap(K_PLUS);
    key_operator_i.tap(K_ENT);
    rd(OFF_DENS, 32'hffff, 32'h5565, "not ready");
    // A restart drops the colour choice, so the default light decides.
    wr(OFF_CTRL, 32'h9);
    check(32'(panel.gaugeLed), 32'h0, "non-default dark");
    key_operator_i.down(K_PLUS);
    key_operator_i.down(K_MINUS);
    repeat (200) @(posedge core_clk);
    key_operator_i.up(K_PLUS);
    key_operator_i.up(K_MINUS);
    repeat (100) @(posedge core_clk);
    rd(OFF_DENS, 32'hffff, 32'h5555, "restore");
  endtask

  task automatic t_lock();
    pages = 0;
    wr(OFF_CTRL, 32'h3);
    key_operator_i.tap(K_TEST);
    check(pages, 0, "locked page");
    wr(OFF_CTRL, 32'h5);
    key_operator_i.tap(K_TEST);
    check(pages, 1, "page");
  endtask

  task automatic t_sep();
    key_operator_i.down(K_SEL);
    repeat (3) key_operator_i.tap(K_ENT);
    key_operator_i.up(K_SEL);
    repeat (100) @(posedge core_clk);
    rd(OFF_STAT, 32'h1f, 32'h8, "sep mode");
    check(32'(panel.tonerLed[2:1]), 32'h0, "sep lights");
    repeat (3) key_operator_i.tap(K_PLUS);
    key_operator_i.tap(K_ENT);
    check(32'(panel.sepDesig), 32'h6, "sep clamp");
    repeat (400) @(posedge core_clk);
    wr(OFF_CTRL, 32'h9);
    check(32'(panel.sepDesig), 32'h4, "sep restart");
  endtask

  task automatic t_pat();
    key_operator_i.down(K_SEL);
    repeat (8) key_operator_i.tap(K_ENT);
    key_operator_i.up(K_SEL);
    repeat (100) @(posedge core_clk);
    rd(OFF_STAT, 32'h1f, 32'h4, "pat mode");
    key_operator_i.tap(K_MINUS);
    repeat (5) key_operator_i.tap(K_PLUS);
    key_operator_i.tap(K_ENT);
    check(32'(panel.pattern), 32'h9, "pattern");
    rd(OFF_STAT, 32'h1f, 32'h4, "still pat");
    repeat (300) @(posedge core_clk);
    rd(OFF_STAT, 32'h1f, 32'h2, "idle exit");
    wr(OFF_CTRL, 32'h9);
    check(32'(panel.pattern), 32'h4, "pat restart");
  endtask

  task automatic t_bus();
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(8'h40, d, r);
    check({30'h0, r}, 32'h2, "unmapped read");
    axi_write(8'h40, 32'h1, r);
    check({30'h0, r}, 32'h2, "unmapped write");
  endtask

  task automatic t_service();
    do_reset(1'b1);
    key_operator_i.up(K_TEST);
    check(chimes, 0, "silent boot");
    rd(OFF_STAT, 32'h1f, 32'h10, "service");
    wr(OFF_CTRL, 32'h1);
    key_operator_i.tap(K_SEL);
    check(32'(panel.tonerLed[2:0]), 32'h1, "item lead");
    key_operator_i.tap(K_PLUS);
    key_operator_i.tap(K_ENT);
    rd(OFF_OFFS, 32'hff, 32'h0c, "lead step");
    key_operator_i.tap(K_SEL);
    check(32'(panel.tonerLed[2:0]), 32'h2, "item two");
    key_operator_i.tap(K_MINUS);
    key_operator_i.tap(K_ENT);
    rd(OFF_OFFS, 32'hff00, 32'hef00, "side step");
    wr(OFF_CTRL, 32'h9);
    rd(OFF_REGS, 32'hfff, 32'h546, "regs kept");
  endtask

  // A hang is cut short long after the expected run time.
  initial begin
    repeat (60000) @(posedge core_clk);
    fails++;
    final_report();
  end

  initial begin
    t_boot();
    t_density();
    t_lock();
    t_sep();
    t_pat();
    t_bus();
    t_service();
    final_report();
  end
endmodule
